/* File: ext_bus_pkg.sv */
package ext_bus_pkg;

  // ***********************************************************
  // Widths
  // ***********************************************************
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;

  // ***********************************************************
  // Size encodings
  // ***********************************************************
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;

  // ***********************************************************
  // Port size encodings
  // ***********************************************************
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_8  = 2'h2;

  // ***********************************************************
  // Address offsets within a longword
  // ***********************************************************
  localparam logic [1:0] OFS_0 = 2'h0;
  localparam logic [1:0] OFS_1 = 2'h1;
  localparam logic [1:0] OFS_2 = 2'h2;
  localparam logic [1:0] OFS_3 = 2'h3;

  // Second-half address step for a split longword
  localparam logic [1:0] HALF_STEP = 2'h2;

  // Access mode levels in the second clock
  localparam logic MODE_SUPER = 1'b1;
  localparam logic MODE_USER  = 1'b0;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_WAIT} seq_state_e;

endpackage

/* File: write_lane_mux.sv */
module write_lane_mux
  import ext_bus_pkg::*;
(
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  offset,
  input  wire logic [31:0] operand,
  output logic      [31:0] laneData
);

  // ***********************************************************
  // Write lane steering
  // ***********************************************************
  logic [7:0] opMsb;
  logic [7:0] opSecond;
  logic [7:0] opThird;
  logic [7:0] opLsb;

  assign opMsb    = operand[31:24];
  assign opSecond = operand[23:16];
  assign opThird  = operand[15:8];
  assign opLsb    = operand[7:0];

  // Don't-care lanes are driven with zero
  always_comb
  begin
    laneData = 32'h0000_0000;
    if (size == SIZE_BYTE)
    begin
      laneData[31:24] = opLsb;                                       // [RULE_15]
      if (offset == OFS_1 || offset == OFS_3)
        laneData[23:16] = opLsb;                                     // [RULE_15]
      if (offset == OFS_2)
        laneData[15:8] = opLsb;                                      // [RULE_15]
      if (offset == OFS_3)
        laneData[7:0] = opLsb;                                       // [RULE_15]
    end
    else if (size == SIZE_WORD)
    begin
      unique case (offset)
        OFS_0: laneData = {opThird, opLsb, 16'h0000};                // [RULE_16]
        OFS_2: laneData = {opThird, opLsb, opThird, opLsb};          // [RULE_16]
        default: laneData = {opLsb, 24'h00_0000};
      endcase
    end
    else
    begin
      unique case (offset)
        OFS_0: laneData = {opMsb, opSecond, opThird, opLsb};         // [RULE_16]
        OFS_1: laneData = {opSecond, 24'h00_0000};                   // [RULE_16]
        OFS_2: laneData = {opThird, opLsb, 16'h0000};                // [RULE_16]
        default: laneData = {opLsb, 24'h00_0000};
      endcase
    end
  end

endmodule

/* File: read_lane_mux.sv */
module read_lane_mux
  import ext_bus_pkg::*;
(
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  offset,
  input  wire logic [1:0]  portSize,
  input  wire logic        secondHalf,
  input  wire logic [31:0] busData,
  input  wire logic [31:0] prevData,
  output logic      [31:0] operand
);

  // ***********************************************************
  // Read lane gathering, don't-care lanes ignored
  // ***********************************************************
  always_comb
  begin
    operand = prevData;
    if (portSize == PORT_8)
    begin
      operand = {24'h00_0000, busData[31:24]};                        // [RULE_19]
    end
    else if (portSize == PORT_16)
    begin
      if (size == SIZE_BYTE)
        operand = {24'h00_0000, offset[0] ? busData[23:16] : busData[31:24]}; // [RULE_21]
      else if (size == SIZE_WORD)
        operand = {16'h0000, busData[31:16]};                         // [RULE_19]
      else if (secondHalf)
        operand = {prevData[31:16], busData[31:16]};                  // [RULE_14]
      else
        operand = {busData[31:16], 16'h0000};                         // [RULE_14]
    end
    else
    begin
      unique case (size)
        SIZE_BYTE:
        begin
          unique case (offset)
            OFS_0: operand = {24'h00_0000, busData[31:24]};           // [RULE_21]
            OFS_1: operand = {24'h00_0000, busData[23:16]};
            OFS_2: operand = {24'h00_0000, busData[15:8]};
            OFS_3: operand = {24'h00_0000, busData[7:0]};
          endcase
        end
        SIZE_WORD: operand = {16'h0000, offset[1] ? busData[15:0] : busData[31:16]};
        SIZE_LONG: operand = busData;
        SIZE_LINE: operand = busData;
      endcase
    end
  end

endmodule

/* File: ext_bus_single_transfer.sv */
// Notes on behaviour
// RULE_01 - First clock drives address, type, mode, direction, size and start strobe.
// RULE_02 - Transfer type outputs name the kind of access.
// RULE_03 - Direction high for whole read, low for whole write.
// RULE_04 - Size code: 00 longword, 10 word, 01 byte, 11 line.
// RULE_05 - First clock of a read: mode shows code fetch or data read.
// RULE_06 - First clock of a write: mode shows data write.
// RULE_07 - Second clock negates start strobe, mode high for supervisor.
// RULE_08 - Slave drives read data on its lanes and acknowledges.
// RULE_09 - Acknowledge sampled end of second clock; read data captured, cycle ends. Code: zero-wait cycle ends after fifth clock, data from end of third.
// RULE_10 - Without acknowledge, wait states; sample each later rising edge.
// RULE_11 - Bus monitor expiry before acknowledge ends cycle with bus error.
// RULE_12 - 32-bit slave returns byte n on lane n from top.
// RULE_13 - 16-bit slave uses upper half, 8-bit top lane only.
// RULE_14 - Longword to 16-bit port: two words at offsets 0 and 2.
// RULE_15 - Byte write on top lane, copied onto addressed lane.
// RULE_16 - Word, longword, line writes placed from addressed position on top lanes.
// RULE_17 - Second clock drives mode low for user access.
// RULE_18 - Port size taken per transfer at start of each bus cycle.
// RULE_19 - 32-bit full bus, 16-bit upper half, 8-bit top lane.
// RULE_20 - Zero-wait transfer lasts two clocks; next start may follow. Code: five clocks, then one ST_IDLE clock before the next start.
// RULE_21 - Don't-care lanes ignored when assembling read operand.
module ext_bus_single_transfer
  import ext_bus_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Request side
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic                      reqRead,
  input  wire logic [1:0]                reqType,
  input  wire logic [1:0]                reqSize,
  input  wire logic                      reqCode,
  input  wire logic                      reqSuper,
  input  wire logic [1:0]                reqPortSize,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] reqWriteData,
  // Completion side
  output logic                           doneValid,
  output logic                           doneError,
  output logic      [ext_bus_pkg::DATA_W-1:0] doneReadData,
  // Bus monitor expiry from the timer
  input  wire logic                      busTimeout,
  // External bus pins
  output logic      [ext_bus_pkg::ADDR_W-1:0] busAddr,
  output logic      [1:0]                xfer_type,
  output logic      [1:0]                xfer_size,
  output logic                           access_kind_mode,
  output logic                           readNotWrite,
  output logic                           xfer_start_n,
  input  wire logic                      xfer_ack_n,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] dataIn,
  output logic      [ext_bus_pkg::DATA_W-1:0] dataOut,
  output logic                           dataOutEn
);

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic [2:0]  ackSync_reg;
  logic [2:0]  ackSync_next;
  logic [2:0]  toSync_reg;
  logic [2:0]  toSync_next;
  logic        ackSeen;
  logic        timeoutSeen;

  // Acknowledge and timeout pass three stages; second and third must agree
  always_comb
  begin
    ackSync_next = {ackSync_reg[1:0], ~xfer_ack_n};
    toSync_next  = {toSync_reg[1:0], busTimeout};
    ackSeen      = ackSync_reg[1] & ackSync_reg[2];
    timeoutSeen  = toSync_reg[1] & toSync_reg[2];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ackSync_reg <= 3'h0;
      toSync_reg  <= 3'h0;
    end
    else
    begin
      ackSync_reg <= ackSync_next;
      toSync_reg  <= toSync_next;
    end
  end

  // ***********************************************************
  // Read data alignment
  // ***********************************************************
  logic [DATA_W-1:0]           dinEarly_reg;
  logic [DATA_W-1:0]           dinEarly_next;
  logic [DATA_W-1:0]           dinLate_reg;
  logic [DATA_W-1:0]           dinLate_next;

  // Read lanes trail the pins by two clocks, so the word used is the one
  // that stood at the edge where the acknowledge entered its second stage
  always_comb
  begin
    dinEarly_next = dataIn;
    dinLate_next  = dinEarly_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dinEarly_reg <= 32'h0000_0000;
      dinLate_reg  <= 32'h0000_0000;
    end
    else
    begin
      dinEarly_reg <= dinEarly_next;
      dinLate_reg  <= dinLate_next;
    end
  end

  // ***********************************************************
  // Cycle state
  // ***********************************************************
  seq_state_e                  state_reg;
  seq_state_e                  state_next;
  logic [ADDR_W-1:0]           addr_reg;
  logic [ADDR_W-1:0]           addr_next;
  logic [1:0]                  type_reg;
  logic [1:0]                  type_next;
  logic [1:0]                  size_reg;
  logic [1:0]                  size_next;
  logic [1:0]                  port_reg;
  logic [1:0]                  port_next;
  logic                        read_reg;
  logic                        read_next;
  logic                        code_reg;
  logic                        code_next;
  logic                        super_reg;
  logic                        super_next;
  logic                        half_reg;
  logic                        half_next;
  logic [DATA_W-1:0]           wdata_reg;
  logic [DATA_W-1:0]           wdata_next;
  logic [DATA_W-1:0]           rdata_reg;
  logic [DATA_W-1:0]           rdata_next;
  logic                        done_reg;
  logic                        done_next;
  logic                        err_reg;
  logic                        err_next;
  logic [DATA_W-1:0]           laneData;
  logic [DATA_W-1:0]           gathered;
  logic                        splitLong;

  // Only longwords and lines to a 16-bit port are split in two
  assign splitLong = (port_reg == PORT_16) &&
                     (size_reg == SIZE_LONG || size_reg == SIZE_LINE);

  write_lane_mux write_lane_mux_inst
  (
    .size    (size_reg),
    .offset  (addr_reg[1:0]),
    .operand (wdata_reg),
    .laneData(laneData)
  );

  read_lane_mux read_lane_mux_inst
  (
    .size      (size_reg),
    .offset    (addr_reg[1:0]),
    .portSize  (port_reg),
    .secondHalf(half_reg),
    .busData   (dinLate_reg),
    .prevData  (rdata_reg),
    .operand   (gathered)
  );

  // Next-state and capture logic
  always_comb
  begin
    state_next = state_reg;
    addr_next  = addr_reg;
    type_next  = type_reg;
    size_next  = size_reg;
    port_next  = port_reg;
    read_next  = read_reg;
    code_next  = code_reg;
    super_next = super_reg;
    half_next  = half_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (reqValid)
        begin
          state_next = ST_FIRST;
          addr_next  = reqAddr;                                      // [RULE_01]
          type_next  = reqType;                                      // [RULE_02]
          size_next  = reqSize;                                      // [RULE_04]
          port_next  = reqPortSize;                                  // [RULE_18]
          read_next  = reqRead;                                      // [RULE_03]
          code_next  = reqCode & reqRead;                            // [RULE_05] [RULE_06]
          super_next = reqSuper;
          half_next  = 1'b0;
          wdata_next = reqWriteData;
        end
      end
      ST_FIRST, ST_WAIT:
      begin
        state_next = ST_WAIT;                                        // [RULE_10]
        if (ackSeen)                                                 // [RULE_09]
        begin
          if (read_reg)
            rdata_next = gathered;                                   // [RULE_09] [RULE_21]
          if (splitLong && !half_reg)
          begin
            // Second word of a split longword
            half_next  = 1'b1;                                       // [RULE_14]
            addr_next  = {addr_reg[ADDR_W-1:2], HALF_STEP};          // [RULE_14]
            wdata_next = {wdata_reg[15:0], wdata_reg[15:0]};         // [RULE_14]
            state_next = ST_FIRST;
          end
          else
          begin
            state_next = ST_IDLE;                                    // [RULE_20]
            done_next  = 1'b1;
          end
        end
        else if (timeoutSeen)
        begin
          state_next = ST_IDLE;                                      // [RULE_11]
          done_next  = 1'b1;
          err_next   = 1'b1;                                         // [RULE_11]
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      addr_reg  <= '0;
      type_reg  <= 2'h0;
      size_reg  <= SIZE_LONG;
      port_reg  <= PORT_32;
      read_reg  <= 1'b1;
      code_reg  <= 1'b0;
      super_reg <= 1'b0;
      half_reg  <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      type_reg  <= type_next;
      size_reg  <= size_next;
      port_reg  <= port_next;
      read_reg  <= read_next;
      code_reg  <= code_next;
      super_reg <= super_next;
      half_reg  <= half_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
    end
  end

  // ***********************************************************
  // Pin drive
  // ***********************************************************
  logic firstClock;
  logic active;

  assign firstClock = (state_reg == ST_FIRST) && !half_reg ||
                      (state_reg == ST_FIRST) && half_reg;
  assign active     = (state_reg != ST_IDLE);

  // Control pins from held request state
  always_comb
  begin
    busAddr          = addr_reg;                                     // [RULE_01]
    xfer_type        = type_reg;                                     // [RULE_02]
    xfer_size        = size_reg;                                     // [RULE_04]
    readNotWrite     = read_reg;                                     // [RULE_03]
    xfer_start_n     = !firstClock;                                  // [RULE_01] [RULE_07]
    if (firstClock)
      access_kind_mode = code_reg;                                   // [RULE_05] [RULE_06]
    else
      access_kind_mode = super_reg ? MODE_SUPER : MODE_USER;         // [RULE_07] [RULE_17]
    dataOut          = laneData;                                     // [RULE_15] [RULE_16]
    dataOutEn        = active && !read_reg;
  end

  // Request and completion handshakes
  assign reqReady     = (state_reg == ST_IDLE);                      // [RULE_20]
  assign doneValid    = done_reg;
  assign doneError    = err_reg;
  assign doneReadData = rdata_reg;

endmodule

/* File: ext_bus_single_transfer_props.sv */
module ext_bus_single_transfer_props
  import ext_bus_pkg::*;
(
  input wire logic                             clk,
  input wire logic                             reset_n,
  input wire logic                             reqValid,
  input wire logic                             reqReady,
  input wire logic                             reqRead,
  input wire logic [1:0]                       reqSize,
  input wire logic                             reqCode,
  input wire logic                             reqSuper,
  input wire logic [1:0]                       reqPortSize,
  input wire logic                             doneValid,
  input wire logic                             doneError,
  input wire logic                             busTimeout,
  input wire logic [ext_bus_pkg::ADDR_W-1:0]   busAddr,
  input wire logic [1:0]                       xfer_size,
  input wire logic                             access_kind_mode,
  input wire logic                             readNotWrite,
  input wire logic                             dataOutEn,
  input wire logic                             xfer_start_n,
  input wire logic                             xfer_ack_n
);
  // *****
  // Bus cycle checks
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_start_one_clock: assert property (!xfer_start_n |=> xfer_start_n)
    else $error("start strobe held past first clock");
  a_taken_starts: assert property (reqValid && reqReady |=> !xfer_start_n)
    else $error("no start strobe after request taken");
  a_pins_held: assert property (!xfer_start_n |=> $stable(busAddr)
    && $stable(xfer_size) && $stable(readNotWrite))
    else $error("address or control changed after first clock");
  a_dir_matches: assert property (reqValid && reqReady |=>
    readNotWrite == $past(reqRead) && dataOutEn != $past(reqRead))
    else $error("direction wrong for access");
  a_mode_first: assert property (reqValid && reqReady |=>
    access_kind_mode == ($past(reqRead) && $past(reqCode)))
    else $error("first clock mode wrong");
  a_mode_second: assert property (reqValid && reqReady |=> ##1
    access_kind_mode == $past(reqSuper, 2))
    else $error("second clock mode wrong");
  a_size_code: assert property (reqValid && reqReady && reqPortSize == PORT_32 |=>
    xfer_size == $past(reqSize))
    else $error("size code wrong");
  a_ack_ends: assert property ($fell(xfer_ack_n) |->
    ##[1:6] (doneValid || !xfer_start_n))
    else $error("acknowledge did not end the cycle");
  a_wait_no_done: assert property ((xfer_ack_n && !busTimeout)[*6] |-> !doneValid)
    else $error("completion without acknowledge");
  a_error_with_done: assert property (doneError |-> doneValid)
    else $error("error flag without completion");
  a_timeout_error: assert property (busTimeout[*6] ##0 doneValid |-> doneError)
    else $error("expired monitor ended cycle without error");
endmodule

bind ext_bus_single_transfer ext_bus_single_transfer_props props_inst (.clk, .reset_n,
  .reqValid, .reqReady, .reqRead, .reqSize, .reqCode, .reqSuper, .reqPortSize, .doneValid,
  .doneError, .busTimeout, .busAddr, .xfer_size, .access_kind_mode, .readNotWrite,
  .dataOutEn, .xfer_start_n, .xfer_ack_n);

/* File: slave_model.sv */
module slave_model
  import ext_bus_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] busAddr,
  input  wire logic                           xfer_start_n,
  input  wire logic [31:0]                    dataOut,
  input  wire logic [1:0]                     portSize,
  input  wire logic                           mute,
  input  wire logic [3:0]                     waits,
  output logic                                xfer_ack_n,
  output logic      [31:0]                    dataIn,
  output logic      [31:0]                    lastWrite
);
  int   cnt = 0;
  int   ackLeft = 0;
  logic st;
  logic [27:0] a;

  // Memory content is a pattern of the byte address
  function automatic logic [7:0] mem(input logic [27:0] x);
    return x[7:0] ^ 8'hA5;
  endfunction

  // Slave answers after the set wait count, holds acknowledge two clocks
  always @(posedge clk)
  begin
    st = xfer_start_n;
    #1;
    if (!st && !mute)
      cnt = waits + 1;
    if (ackLeft > 0)
    begin
      ackLeft--;
      if (ackLeft == 0)
      begin
        xfer_ack_n = 1'b1;
        dataIn = ~dataIn; // Released bus shows no stale data
      end
    end
    else if (cnt > 0)
    begin
      cnt--;
      if (cnt == 0)
      begin
        a = busAddr;
        case (portSize)
          PORT_32: dataIn = {mem({a[27:2], 2'h0}), mem({a[27:2], 2'h1}),
            mem({a[27:2], 2'h2}), mem({a[27:2], 2'h3})};
          PORT_16: dataIn = {mem({a[27:1], 1'b0}), mem({a[27:1], 1'b1}), ~dataIn[15:0]};
          default: dataIn = {mem(a), ~dataIn[23:0]};
        endcase
        xfer_ack_n = 1'b0;
        ackLeft = 2;
        lastWrite = dataOut;
      end
    end
  end

  // Idle bus at start
  initial
  begin
    xfer_ack_n = 1'b1;
    dataIn = 32'h5A5A5A5A;
    lastWrite = 32'h0;
  end
endmodule

/* File: ext_bus_single_transfer_bench.sv */
module ext_bus_single_transfer_bench
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic rd; logic [1:0] sz, ofs, ps; logic sm, cd; logic [31:0] ex;} row_s;
  logic        clk, reset_n, reqValid, reqReady, reqRead, reqCode, reqSuper, doneValid;
  logic        doneError, busTimeout, access_kind_mode, readNotWrite, xfer_start_n;
  logic        xfer_ack_n, dataOutEn, mute;
  logic [1:0]  reqType, reqSize, reqPortSize, xfer_type, xfer_size;
  logic [3:0]  waits;
  logic [27:0] reqAddr, busAddr;
  logic [31:0] reqWriteData, doneReadData, dataIn, dataOut, lastWrite;
  int          errTotal = 0;
  int          checked = 0;
  int          starts = 0;
  int          lat, z0, s0, nExp;
  // Columns: read, size, offset, port, super, code, expected operand or lanes
  row_s rows[20] = '{'{1,1,0,0,1,1,32'h95}, '{1,1,1,0,0,0,32'h94}, '{1,1,2,0,1,0,32'h97},
    '{1,1,3,0,0,1,32'h96}, '{1,2,0,0,1,0,32'h9594}, '{1,2,2,0,0,0,32'h9796},
    '{1,0,0,0,1,1,32'h95949796}, '{1,3,0,0,0,0,32'h95949796}, '{1,0,0,1,1,0,32'h95949796},
    '{1,2,2,1,0,1,32'h9796}, '{1,1,3,2,1,0,32'h96}, '{1,1,1,1,0,0,32'h94},
    '{0,1,0,0,1,0,32'h44000000}, '{0,1,1,0,0,0,32'h44440000}, '{0,1,2,0,1,0,32'h44004400},
    '{0,1,3,0,0,0,32'h44440044}, '{0,2,0,0,1,0,32'h33440000}, '{0,2,2,0,0,0,32'h33443344},
    '{0,0,0,0,1,0,32'h11223344}, '{0,3,0,0,0,0,32'h11223344}};

  ext_bus_single_transfer ext_bus_single_transfer_inst (.clk, .reset_n, .reqValid, .reqReady,
    .reqAddr, .reqRead, .reqType, .reqSize, .reqCode, .reqSuper, .reqPortSize, .reqWriteData,
    .doneValid, .doneError, .doneReadData, .busTimeout, .busAddr, .xfer_type, .xfer_size,
    .access_kind_mode, .readNotWrite, .xfer_start_n, .xfer_ack_n, .dataIn, .dataOut,
    .dataOutEn);
  slave_model slave_model_inst (.clk, .busAddr, .xfer_start_n, .dataOut,
    .portSize(reqPortSize), .mute, .waits, .xfer_ack_n, .dataIn, .lastWrite);

  // Clock and bus cycle counter
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
    if (xfer_start_n === 1'b0) starts++;

  // *****
  // Helpers
  // *****
  task automatic completeRun();
    $display("Checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Lanes that carry operand bytes; the rest are don't-care
  function automatic logic [31:0] mk(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      mk[i*8 +: 8] = (v[i*8 +: 8] != 8'h0) ? 8'hFF : 8'h00;
  endfunction

  task automatic xfer(input row_s r, input logic to);
    int n;
    @(posedge clk);
    #1;
    reqAddr = {20'h00012, 4'h3, 2'h0, r.ofs};
    {reqRead, reqSize, reqPortSize, reqSuper, reqCode} = {r.rd, r.sz, r.ps, r.sm, r.cd};
    reqType = {r.sm, r.cd};
    reqValid = 1'b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50)
    begin
      errTotal++;
      completeRun();
    end
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    check({30'h0, xfer_type}, {30'h0, reqType});
    check({4'h0, busAddr}, {4'h0, reqAddr});
    n = 0;
    while (doneValid !== 1'b1 && n < 300)
    begin
      if (n == 8 && to) busTimeout = 1'b1;
      @(posedge clk);
      #1;
      n++;
    end
    busTimeout = 1'b0;
    lat = n;
    if (n >= 300)
    begin
      errTotal++;
      completeRun();
    end
  endtask

  // *****
  // Main sequence
  // *****
  initial
  begin
    {reset_n, reqValid, reqRead, reqCode, reqSuper, busTimeout, mute} = 7'h00;
    {reqType, reqSize, reqPortSize, waits, reqAddr} = 38'h0;
    reqWriteData = 32'h11223344;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      s0 = starts;
      xfer(rows[i], 1'b0);
      if (i == 0) z0 = lat;
      if (rows[i].rd) check(doneReadData, rows[i].ex);
      else check(lastWrite & mk(rows[i].ex), rows[i].ex);
      nExp = (rows[i].ps == 1 && rows[i].sz[1] == rows[i].sz[0]) ? 2 : 1;
      check(32'(starts - s0), 32'(nExp));
    end
    // Wait states stretch the cycle by exactly their count
    waits = 4'h5;
    xfer(rows[6], 1'b0);
    check(32'(lat), 32'(z0 + 5));
    check(doneReadData, rows[6].ex);
    waits = 4'h0;
    // Silent slave ends in a bus error
    mute = 1'b1;
    xfer(rows[0], 1'b1);
    check({31'h0, doneError}, 32'h1);
    mute = 1'b0;
    repeat (6) @(posedge clk);
    // Reset in the second clock of a cycle
    #1;
    reqValid = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b0;
    reqValid = 1'b0;
    #1;
    check({28'h0, xfer_start_n, readNotWrite, dataOutEn, doneValid}, 32'hC);
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    xfer(rows[3], 1'b0);
    check(doneReadData, rows[3].ex);
    completeRun();
  end
endmodule
